// [rtl/hsp_pkg.sv]
package hsp_pkg;

  // Clock rate in kHz and in MHz
  localparam int CLK_KHZ = 200000;
  localparam int CLK_MHZ = 200;

  // Times as printed, in their own units
  localparam int CYCLE_FAST_MS = 17;
  localparam int CYCLE_MED_MS = 67;
  localparam int CYCLE_SLOW_MS = 260;
  localparam int AD_FAST_US = 12200;
  localparam int AD_MED_US = 62600;
  localparam int AD_SLOW_US = 256000;
  localparam int TRIG_DELAY_MS = 1;
  localparam int OUT_TO_EOC_US = 10;
  localparam int CHARGE_TO_MEAS_MS = 100;
  localparam int DISCHARGE_REQUEST_N_MIN_MS = 10;
  localparam int RECORD_HOLD_MS = 100;

  // Derived cycle counts (exact products of each time and the clock rate, no rounding)
  localparam int CYCLE_FAST_CLK = CYCLE_FAST_MS * CLK_KHZ;
  localparam int CYCLE_MED_CLK = CYCLE_MED_MS * CLK_KHZ;
  localparam int CYCLE_SLOW_CLK = CYCLE_SLOW_MS * CLK_KHZ;
  localparam int AD_FAST_CLK = AD_FAST_US * CLK_MHZ;
  localparam int AD_MED_CLK = AD_MED_US * CLK_MHZ;
  localparam int AD_SLOW_CLK = AD_SLOW_US * CLK_MHZ;
  localparam int TRIG_DELAY_CLK = TRIG_DELAY_MS * CLK_KHZ;
  localparam int OUT_TO_EOC_CLK = OUT_TO_EOC_US * CLK_MHZ;
  localparam int CHARGE_TO_MEAS_CLK = CHARGE_TO_MEAS_MS * CLK_KHZ;
  localparam int DISCHARGE_REQUEST_N_MIN_CLK = DISCHARGE_REQUEST_N_MIN_MS * CLK_KHZ;
  localparam int RECORD_HOLD_CLK = RECORD_HOLD_MS * CLK_KHZ;

  localparam int CNT_W = 27;

  // Reset values of the active-low outputs
  localparam logic OUT_IDLE = 1'h1;

  // Measurement rate selection
  typedef enum logic [1:0] {
    HSP_RATE_FAST = 2'h0,
    HSP_RATE_MED = 2'h1,
    HSP_RATE_SLOW = 2'h2
  } hsp_rate_t;

  // Trigger source selection
  typedef enum logic [1:0] {
    HSP_TRIG_INT = 2'h0,
    HSP_TRIG_MAN = 2'h1,
    HSP_TRIG_EXT = 2'h2
  } hsp_trig_t;

  typedef enum logic [2:0] {
    HSP_ST_DISCHARGE_REQUEST_N = 3'h0,
    HSP_ST_CHARGE = 3'h1,
    HSP_ST_WAIT = 3'h2,
    HSP_ST_DELAY = 3'h3,
    HSP_ST_CONV = 3'h4,
    HSP_ST_PRESENT = 3'h5,
    HSP_ST_REST = 3'h6
  } hsp_state_t;

  // Measurement result from the analog side
  typedef struct packed {
    logic good;
    logic fail;
    logic contact_fail;
    logic no_voltage;
  } hsp_result_t;

  // Handler outputs, all active low
  typedef struct packed {
    logic contact_fail_n;
    logic no_voltage_out_n;
    logic result_good_n;
    logic result_fail_n;
    logic eoc_n;
  } hsp_handler_out_t;

endpackage : hsp_pkg

// [rtl/hsp_handler_port.sv]
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Rising edge on external trigger starts a measurement when external trigger chosen.
// - Charge request low enters test state; discharge request low enters discharge.
// - All handler outputs are active low, idle high.
// - A measurement cycle stays within 17, 67 or 260 ms by rate.
// - Good/fail outputs appear about 10 us before end-of-conversion asserts.
// - Measuring begins about 100 ms after charge request is recognised.
// - In discharge state the recorded results stay stable about 100 ms.
// - Trigger sources are internal, manual/remote and external.
module hsp_handler_port #(
  parameter int CYCLE_FAST = hsp_pkg::CYCLE_FAST_CLK,
  parameter int CYCLE_MED = hsp_pkg::CYCLE_MED_CLK,
  parameter int CYCLE_SLOW = hsp_pkg::CYCLE_SLOW_CLK,
  parameter int AD_FAST = hsp_pkg::AD_FAST_CLK,
  parameter int AD_MED = hsp_pkg::AD_MED_CLK,
  parameter int AD_SLOW = hsp_pkg::AD_SLOW_CLK,
  parameter int TRIG_DELAY = hsp_pkg::TRIG_DELAY_CLK,
  parameter int CHARGE_TO_MEAS = hsp_pkg::CHARGE_TO_MEAS_CLK,
  parameter int DISCHARGE_REQUEST_N_MIN = hsp_pkg::DISCHARGE_REQUEST_N_MIN_CLK,
  parameter int RECORD_HOLD = hsp_pkg::RECORD_HOLD_CLK
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic DISCHARGE_REQUEST_N,
  input wire logic CHARGE_TEST_REQUEST_N,
  input wire logic EXT_TRIGGER_IN,
  input wire hsp_pkg::hsp_rate_t RATE,
  input wire hsp_pkg::hsp_trig_t TRIG_SOURCE,
  input wire logic MANUAL_TRIGGER,
  input wire hsp_pkg::hsp_result_t MEAS_RESULT,
  output logic CONTACT_FAIL_N,
  output logic NO_VOLTAGE_OUT_N,
  output logic RESULT_GOOD_N,
  output logic RESULT_FAIL_N,
  output logic EOC_N,
  output logic TEST_STATE,
  output logic CONVERTING
);

  typedef struct packed {
    hsp_pkg::hsp_state_t state;
    logic [2:0] discharge_request_n_sync;
    logic [2:0] charge_sync;
    logic [2:0] trig_sync;
    logic discharge_request_n_level;
    logic charge_level;
    logic trig_level;
    logic [hsp_pkg::CNT_W-1:0] timer;
    logic [hsp_pkg::CNT_W-1:0] cycle_timer;
    logic [hsp_pkg::CNT_W-1:0] discharge_request_n_timer;
    logic trig_pending;
    hsp_pkg::hsp_handler_out_t outs;
  } hsp_regs_t;

  hsp_regs_t r;
  hsp_regs_t next_r;

  // Per-rate cycle count as a timer width value
  function automatic logic [hsp_pkg::CNT_W-1:0] hsp_by_rate(
    input hsp_pkg::hsp_rate_t rate, input int fast, input int med, input int slow);
    int v;
    case (rate)
      hsp_pkg::HSP_RATE_FAST: v = fast;
      hsp_pkg::HSP_RATE_MED: v = med;
      default: v = slow;
    endcase
    return v[hsp_pkg::CNT_W-1:0];
  endfunction : hsp_by_rate

  function automatic logic [hsp_pkg::CNT_W-1:0] hsp_cnt(input int v);
    return v[hsp_pkg::CNT_W-1:0];
  endfunction : hsp_cnt

  logic trig_rise;
  logic start_req;
  logic charge_fall;

  always_comb
  begin
    next_r = r;
    trig_rise = 1'b0;
    start_req = 1'b0;
    charge_fall = 1'b0;
    // Three-stage pin synchronisers; a level changes once stages two and three agree
    next_r.discharge_request_n_sync = {r.discharge_request_n_sync[1:0], DISCHARGE_REQUEST_N};
    next_r.charge_sync = {r.charge_sync[1:0], CHARGE_TEST_REQUEST_N};
    next_r.trig_sync = {r.trig_sync[1:0], EXT_TRIGGER_IN};
    if (r.discharge_request_n_sync[1] == r.discharge_request_n_sync[2])
    begin
      next_r.discharge_request_n_level = r.discharge_request_n_sync[2];
    end
    if (r.charge_sync[1] == r.charge_sync[2])
    begin
      next_r.charge_level = r.charge_sync[2];
      charge_fall = r.charge_level && !r.charge_sync[2];
    end
    if (r.trig_sync[1] == r.trig_sync[2])
    begin
      next_r.trig_level = r.trig_sync[2];
      trig_rise = !r.trig_level && r.trig_sync[2];
    end
    // Trigger source select
    case (TRIG_SOURCE)
      hsp_pkg::HSP_TRIG_INT: start_req = 1'b1;
      hsp_pkg::HSP_TRIG_MAN: start_req = MANUAL_TRIGGER;
      hsp_pkg::HSP_TRIG_EXT: start_req = trig_rise;
      default: start_req = 1'b0;
    endcase
    // Discharge request must stay low a minimum time to count
    if (r.discharge_request_n_level)
    begin
      next_r.discharge_request_n_timer = '0;
    end
    else if (r.discharge_request_n_timer != hsp_cnt(DISCHARGE_REQUEST_N_MIN))
    begin
      next_r.discharge_request_n_timer = r.discharge_request_n_timer + 1'b1;
    end
    if (r.timer != '0)
    begin
      next_r.timer = r.timer - 1'b1;
    end
    if (r.cycle_timer != '0)
    begin
      next_r.cycle_timer = r.cycle_timer - 1'b1;
    end
    // An external edge seen during a cycle is kept for the next one
    if (start_req && TRIG_SOURCE == hsp_pkg::HSP_TRIG_EXT)
    begin
      next_r.trig_pending = 1'b1;
    end
    case (r.state)
      hsp_pkg::HSP_ST_DISCHARGE_REQUEST_N:
      begin
        // Results recorded before discharge stay stable for the hold time
        if (r.timer == '0)
        begin
          next_r.outs = '{default: hsp_pkg::OUT_IDLE};
        end
        if (charge_fall)
        begin
          next_r.state = hsp_pkg::HSP_ST_CHARGE;
          next_r.timer = hsp_cnt(CHARGE_TO_MEAS);
          next_r.trig_pending = 1'b0;
        end
      end
      hsp_pkg::HSP_ST_CHARGE:
      begin
        if (r.timer == '0)
        begin
          next_r.state = hsp_pkg::HSP_ST_WAIT;
        end
      end
      hsp_pkg::HSP_ST_WAIT:
      begin
        if (start_req || r.trig_pending)
        begin
          next_r.trig_pending = 1'b0;
          next_r.state = hsp_pkg::HSP_ST_DELAY;
          next_r.timer = hsp_cnt(TRIG_DELAY);
          next_r.cycle_timer = hsp_by_rate(RATE, CYCLE_FAST, CYCLE_MED, CYCLE_SLOW);
        end
      end
      hsp_pkg::HSP_ST_DELAY:
      begin
        if (r.timer == '0)
        begin
          next_r.state = hsp_pkg::HSP_ST_CONV;
          next_r.outs.eoc_n = 1'b1;
          next_r.timer = hsp_by_rate(RATE, AD_FAST, AD_MED, AD_SLOW);
        end
      end
      hsp_pkg::HSP_ST_CONV:
      begin
        if (r.timer == '0)
        begin
          // Results go out first, end-of-conversion follows
          next_r.outs.result_good_n = !MEAS_RESULT.good;
          next_r.outs.result_fail_n = !MEAS_RESULT.fail;
          next_r.outs.contact_fail_n = !MEAS_RESULT.contact_fail;
          next_r.outs.no_voltage_out_n = !MEAS_RESULT.no_voltage;
          next_r.timer = hsp_cnt(hsp_pkg::OUT_TO_EOC_CLK);
          next_r.state = hsp_pkg::HSP_ST_PRESENT;
        end
      end
      hsp_pkg::HSP_ST_PRESENT:
      begin
        if (r.timer == '0)
        begin
          next_r.outs.eoc_n = 1'b0;
          next_r.state = hsp_pkg::HSP_ST_REST;
        end
      end
      hsp_pkg::HSP_ST_REST:
      begin
        // Next start waits for the rate's cycle time
        if (r.cycle_timer == '0)
        begin
          next_r.state = hsp_pkg::HSP_ST_WAIT;
        end
      end
      default: next_r.state = hsp_pkg::HSP_ST_DISCHARGE_REQUEST_N;
    endcase
    // Discharge overrides everything once recognised
    if (!r.discharge_request_n_level && r.discharge_request_n_timer == hsp_cnt(DISCHARGE_REQUEST_N_MIN) - 1'b1)
    begin
      next_r.state = hsp_pkg::HSP_ST_DISCHARGE_REQUEST_N;
      next_r.outs.eoc_n = 1'b1;
      next_r.timer = hsp_cnt(RECORD_HOLD);
      next_r.trig_pending = 1'b0;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      r <= '0;
      r.state <= hsp_pkg::HSP_ST_DISCHARGE_REQUEST_N;
      r.discharge_request_n_sync <= 3'h7;
      r.charge_sync <= 3'h7;
      r.discharge_request_n_level <= 1'b1;
      r.charge_level <= 1'b1;
      r.outs <= '{default: hsp_pkg::OUT_IDLE};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign CONTACT_FAIL_N = r.outs.contact_fail_n;
  assign NO_VOLTAGE_OUT_N = r.outs.no_voltage_out_n;
  assign RESULT_GOOD_N = r.outs.result_good_n;
  assign RESULT_FAIL_N = r.outs.result_fail_n;
  assign EOC_N = r.outs.eoc_n;
  assign TEST_STATE = (r.state != hsp_pkg::HSP_ST_DISCHARGE_REQUEST_N);
  assign CONVERTING = (r.state == hsp_pkg::HSP_ST_CONV);

endmodule : hsp_handler_port

`default_nettype wire

// [tb/hsp_handler_port_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module hsp_handler_port_assertions #(
  parameter int AD_FAST = 1, parameter int AD_MED = 1, parameter int AD_SLOW = 1,
  parameter int TRIG_DELAY = 1, parameter int CHARGE_TO_MEAS = 1,
  parameter int DISCHARGE_REQUEST_N_MIN = 1, parameter int RECORD_HOLD = 1
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic DISCHARGE_REQUEST_N,
  input wire logic CHARGE_TEST_REQUEST_N,
  input wire hsp_pkg::hsp_rate_t RATE,
  input wire hsp_pkg::hsp_trig_t TRIG_SOURCE,
  input wire logic MANUAL_TRIGGER,
  input wire logic CONTACT_FAIL_N,
  input wire logic NO_VOLTAGE_OUT_N,
  input wire logic RESULT_GOOD_N,
  input wire logic RESULT_FAIL_N,
  input wire logic EOC_N,
  input wire logic TEST_STATE,
  input wire logic CONVERTING
);
  int c_conv, c_eoc, c_test, c_dis, c_low, c_man, ad;
  logic [3:0] outs;
  assign outs = {CONTACT_FAIL_N, NO_VOLTAGE_OUT_N, RESULT_GOOD_N, RESULT_FAIL_N};
  always_comb ad = (RATE == hsp_pkg::HSP_RATE_FAST) ? AD_FAST :
    (RATE == hsp_pkg::HSP_RATE_MED) ? AD_MED : AD_SLOW;
  // Cycle counters since each cause
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      c_conv <= 0;
      c_eoc <= 0;
      c_test <= 0;
      c_dis <= 0;
      c_low <= 0;
      c_man <= 0;
    end
    else
    begin
      c_conv <= CONVERTING ? c_conv + 1 : 0;
      c_eoc <= CONVERTING ? 0 : c_eoc + 1;
      c_test <= TEST_STATE ? c_test + 1 : 0;
      c_dis <= TEST_STATE ? 0 : c_dis + 1;
      c_low <= DISCHARGE_REQUEST_N ? 0 : c_low + 1;
      c_man <= MANUAL_TRIGGER ? 0 : c_man + 1;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  a_reset_idle: assert property ($fell(SRST) |-> &outs && EOC_N && !TEST_STATE)
    else $error("outputs not idle after reset");
  a_busy_conv: assert property (CONVERTING |-> EOC_N)
    else $error("end of conversion during conversion");
  a_ad_time: assert property ($fell(CONVERTING) |-> c_conv >= ad - 1 && c_conv <= ad + 2)
    else $error("conversion length wrong");
  a_out_eoc: assert property ($fell(EOC_N) |-> c_eoc inside {[1998:2003]})
    else $error("results to end of conversion gap wrong");
  a_charge_in: assert property (
    $fell(CHARGE_TEST_REQUEST_N) && DISCHARGE_REQUEST_N && !TEST_STATE |-> ##[2:7] TEST_STATE)
    else $error("charge request not taken");
  a_discharge_request_n_force: assert property (c_low > DISCHARGE_REQUEST_N_MIN + 6 |-> !TEST_STATE && EOC_N)
    else $error("discharge request not taken");
  a_meas_delay: assert property ($rose(CONVERTING) |-> c_test >= CHARGE_TO_MEAS)
    else $error("measurement began early");
  a_rec_hold: assert property (
    !TEST_STATE && c_dis > 0 && c_dis < RECORD_HOLD - 2 |-> $stable(outs))
    else $error("results moved in discharge");
  a_man_start: assert property (
    $rose(CONVERTING) && TRIG_SOURCE == hsp_pkg::HSP_TRIG_MAN |-> c_man <= TRIG_DELAY + 3)
    else $error("start without manual trigger");
  c_eoc_fall: cover property ($fell(EOC_N));
  c_discharge_request_n: cover property ($fell(TEST_STATE));
  c_ext: cover property ($rose(CONVERTING) && TRIG_SOURCE == hsp_pkg::HSP_TRIG_EXT);
endmodule : hsp_handler_port_assertions
bind hsp_handler_port hsp_handler_port_assertions #(.AD_FAST(AD_FAST), .AD_MED(AD_MED),
  .AD_SLOW(AD_SLOW), .TRIG_DELAY(TRIG_DELAY), .CHARGE_TO_MEAS(CHARGE_TO_MEAS),
  .DISCHARGE_REQUEST_N_MIN(DISCHARGE_REQUEST_N_MIN), .RECORD_HOLD(RECORD_HOLD)) i_chk (.CLK(CLK), .SRST(SRST),
  .DISCHARGE_REQUEST_N(DISCHARGE_REQUEST_N), .CHARGE_TEST_REQUEST_N(CHARGE_TEST_REQUEST_N),
  .RATE(RATE), .TRIG_SOURCE(TRIG_SOURCE), .MANUAL_TRIGGER(MANUAL_TRIGGER),
  .CONTACT_FAIL_N(CONTACT_FAIL_N), .NO_VOLTAGE_OUT_N(NO_VOLTAGE_OUT_N),
  .RESULT_GOOD_N(RESULT_GOOD_N), .RESULT_FAIL_N(RESULT_FAIL_N), .EOC_N(EOC_N),
  .TEST_STATE(TEST_STATE), .CONVERTING(CONVERTING));
`default_nettype wire

// [tb/hsp_handler_model.sv]
`timescale 1ns/1ps
`default_nettype none
module hsp_handler_model #(
  parameter int CHARGE_HOLD = 30,
  parameter int DISCHARGE_REQUEST_N_HOLD = 13
) (
  input wire logic clk,
  output logic discharge_request_n,
  output logic charge_test_request_n,
  output logic ext_trigger_in
);
  initial
  begin
    discharge_request_n = 1'h1;
    charge_test_request_n = 1'h1;
    ext_trigger_in = 1'h0;
  end
  // Charge request held inside its window
  task automatic charge();
    @(negedge clk) charge_test_request_n = 1'h0;
    repeat (CHARGE_HOLD) @(negedge clk);
    charge_test_request_n = 1'h1;
  endtask : charge
  // Discharge request held past its minimum
  task automatic discharge();
    @(negedge clk) discharge_request_n = 1'h0;
    repeat (DISCHARGE_REQUEST_N_HOLD) @(negedge clk);
    discharge_request_n = 1'h1;
  endtask : discharge
  // Trigger pulse, rising edge starts
  task automatic trigger(input int width);
    @(negedge clk) ext_trigger_in = 1'h1;
    repeat (width) @(negedge clk);
    ext_trigger_in = 1'h0;
  endtask : trigger
endmodule : hsp_handler_model
`default_nettype wire

// [tb/tb_hsp_handler_port.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_hsp_handler_port;
  localparam int TD = 10;
  localparam int CTM = 40;
  localparam int DM = 5;
  localparam int RH = 40;
  localparam int CF = 3000;
  localparam int CM = 3500;
  localparam int CS = 4000;
  localparam int ADF = 100;
  localparam int ADM = 200;
  localparam int ADS = 300;
  localparam int CH = 30;
  logic clk, srst, man;
  hsp_pkg::hsp_rate_t rate;
  hsp_pkg::hsp_trig_t src;
  hsp_pkg::hsp_result_t res;
  wire dn, cn, et, eoc_n, test, conv;
  wire [3:0] outs;
  wire [2:0] sig;
  int failures, n_checks, cyc;
  assign sig = {test, eoc_n, conv};
  hsp_handler_port #(.CYCLE_FAST(CF), .CYCLE_MED(CM), .CYCLE_SLOW(CS), .AD_FAST(ADF),
    .AD_MED(ADM), .AD_SLOW(ADS), .TRIG_DELAY(TD), .CHARGE_TO_MEAS(CTM), .DISCHARGE_REQUEST_N_MIN(DM),
    .RECORD_HOLD(RH)) i_dut (.CLK(clk), .SRST(srst), .DISCHARGE_REQUEST_N(dn),
    .CHARGE_TEST_REQUEST_N(cn), .EXT_TRIGGER_IN(et), .RATE(rate), .TRIG_SOURCE(src),
    .MANUAL_TRIGGER(man), .MEAS_RESULT(res), .CONTACT_FAIL_N(outs[3]),
    .NO_VOLTAGE_OUT_N(outs[2]), .RESULT_GOOD_N(outs[1]), .RESULT_FAIL_N(outs[0]),
    .EOC_N(eoc_n), .TEST_STATE(test), .CONVERTING(conv));
  hsp_handler_model #(.CHARGE_HOLD(CH), .DISCHARGE_REQUEST_N_HOLD(DM + 8)) i_hdl (.clk(clk),
    .discharge_request_n(dn), .charge_test_request_n(cn), .ext_trigger_in(et));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [3:0] code(input hsp_pkg::hsp_result_t r);
    code = ~{r.contact_fail, r.no_voltage, r.good, r.fail};
  endfunction : code
  // Waits at falling edges until sig[w] equals v
  task automatic wait_on(input int w, input logic v, output int n);
    n = 0;
    while (sig[w] !== v && n < 9000)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_on
  task automatic meas(input hsp_pkg::hsp_rate_t r, input hsp_pkg::hsp_result_t v, input int ad);
    int n;
    rate = r;
    res = v;
    wait_on(0, 1'h1, n);
    wait_on(0, 1'h0, n);
    chk(8'(n >= ad - 2 && n <= ad + 2), 8'h01);
    chk({3'h0, eoc_n, outs}, {4'h1, code(v)});
    wait_on(1, 1'h0, n);
    chk(8'(n >= 1996 && n <= 2003), 8'h01);
    chk({3'h0, eoc_n, outs}, {4'h0, code(v)});
  endtask : meas
  task automatic t_charge();
    int n;
    fork
      i_hdl.charge();
    join_none
    wait_on(2, 1'h1, n);
    chk(8'(n <= 8), 8'h01);
    wait_on(0, 1'h1, n);
    chk(8'(n >= CTM), 8'h01);
    meas(hsp_pkg::HSP_RATE_FAST, 4'h8, ADF);
    $display("charge test done");
  endtask : t_charge
  task automatic t_rates();
    meas(hsp_pkg::HSP_RATE_MED, 4'h4, ADM);
    meas(hsp_pkg::HSP_RATE_SLOW, 4'h3, ADS);
    $display("rate test done");
  endtask : t_rates
  task automatic t_trig(input hsp_pkg::hsp_trig_t s);
    int n;
    src = s;
    repeat (4300) @(negedge clk);
    chk({7'h0, conv}, 8'h00);
    if (s == hsp_pkg::HSP_TRIG_MAN)
    begin
      man = 1'h1;
      @(negedge clk) man = 1'h0;
    end
    else
      i_hdl.trigger(TD);
    wait_on(0, 1'h1, n);
    chk(8'(n <= TD + 8), 8'h01);
    wait_on(1, 1'h0, n);
    $display("trigger test done");
  endtask : t_trig
  task automatic t_discharge_request_n();
    i_hdl.discharge();
    chk({6'h0, test, eoc_n}, 8'h01);
    repeat (20) @(negedge clk);
    chk({4'h0, outs}, {4'h0, code(4'h3)});
    repeat (30) @(negedge clk);
    chk({4'h0, outs}, 8'h0F);
    $display("discharge test done");
  endtask : t_discharge_request_n
  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      stop_test();
    end
  end
  initial
  begin
    srst = 1'h1;
    man = 1'h0;
    rate = hsp_pkg::HSP_RATE_FAST;
    src = hsp_pkg::HSP_TRIG_INT;
    res = 4'h8;
    repeat (8) @(negedge clk);
    srst = 1'h0;
    @(negedge clk);
    chk({1'h0, outs, eoc_n, test, conv}, 8'h7C);
    t_charge();
    t_rates();
    t_trig(hsp_pkg::HSP_TRIG_MAN);
    t_trig(hsp_pkg::HSP_TRIG_EXT);
    t_discharge_request_n();
    stop_test();
  end
endmodule : tb_hsp_handler_port
`default_nettype wire
